// ==== design/cbe_exec_core.sv ====
// Execution unit for arithmetic, logic, product, jump, call, skip and branch operations.
`timescale 1ns/100ps
`include "cbe_cfg.svh"
module cbe_exec_core #(
    parameter int PC_W = 22,
    parameter int OFS_W = 12
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire cbe_pkg::cbe_op_type i_op,
    input wire logic [7:0] i_opd,
    input wire logic [7:0] i_ops,
    input wire logic [7:0] i_const,
    input wire logic [15:0] i_pair,
    input wire logic [7:0] i_status,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic [OFS_W-1:0] i_offset,
    input wire logic [PC_W-1:0] i_target,
    input wire logic [15:0] i_zptr,
    input wire logic [7:0] i_jump_high_extension,
    input wire logic [2:0] i_bit_sel,
    input wire logic [2:0] i_flag_sel,
    input wire logic [7:0] i_io_val,
    input wire logic i_next_two_word,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_result_r,
    output logic [7:0] o_result_hi_r,
    output logic o_wr_dst_r,
    output logic o_wr_pair_r,
    output logic o_wr_product_r,
    output logic [7:0] o_status_r,
    output logic o_status_wr_r,
    output logic [PC_W-1:0] o_pc_next_r,
    output logic o_push_r,
    output logic [PC_W-1:0] o_ret_addr_r
);
    import cbe_pkg::*;

    logic [2:0] cnt_r;
    logic [7:0] res_nxt;
    logic [7:0] hi_nxt;
    logic [7:0] st_nxt;
    logic wr_dst_nxt;
    logic wr_pair_nxt;
    logic wr_prod_nxt;
    logic st_wr_nxt;
    logic [PC_W-1:0] pc_nxt;
    logic push_nxt;
    logic [PC_W-1:0] ret_nxt;
    logic [2:0] cyc_nxt;

    // A new operation may start in the last cycle of the previous one.
    wire take = i_start & (cnt_r <= `CBE_CYC_ONE);
    assign o_busy = cnt_r != `CBE_CYC_IDLE;
    assign o_done = cnt_r == `CBE_CYC_ONE;

    // Operand selection for the byte adder.
    wire is_imm = (i_op == op_subtract_constant) | (i_op == op_subtract_constant_with_borrow)
        | (i_op == op_and_with_constant) | (i_op == op_or_with_constant)
        | (i_op == op_clear_bits_by_mask) | (i_op == op_compare_immediate);
    wire use_cin = (i_op == op_add_carry) | (i_op == op_sub_carry)
        | (i_op == op_subtract_constant_with_borrow) | (i_op == op_compare_with_borrow);
    wire is_sub = (i_op != op_add) & (i_op != op_add_carry);
    wire is_cmp = (i_op == op_compare) | (i_op == op_compare_with_borrow)
        | (i_op == op_compare_immediate);
    wire keep_z = use_cin & is_sub;
    wire [7:0] opb = is_imm ? i_const : i_ops;
    wire [7:0] sum;
    wire add_c;
    wire add_h;
    wire add_v;

    cbe_add8 u_add8 (
        .i_a(i_opd),
        .i_b(opb),
        .i_cin(use_cin & i_status[`CBE_FLAG_C]),
        .i_sub(is_sub),
        .o_sum(sum),
        .o_carry(add_c),
        .o_half(add_h),
        .o_ovf(add_v)
    );

    // With-carry subtracts only clear Z, so multi-byte zero tests chain.
    wire add_z = (sum == `CBE_BYTE_RST) & (~keep_z | i_status[`CBE_FLAG_Z]);

    // Word arithmetic on the register pair with a six-bit constant.
    wire w_sub = i_op == op_word_immediate_subtract;
    wire [15:0] w_k = {10'h000, i_const[5:0]};
    wire [15:0] w_res = w_sub ? (i_pair - w_k) : (i_pair + w_k);
    wire w_c = w_sub ? (w_res[15] & ~i_pair[15]) : (~w_res[15] & i_pair[15]);
    wire w_v = w_sub ? (i_pair[15] & ~w_res[15]) : (~i_pair[15] & w_res[15]);

    // Logic results.
    wire [7:0] clear_mask = `CBE_ALL_ONES - i_const;
    wire [7:0] log_res =
        (i_op == op_and) ? (i_opd & i_ops) :
        (i_op == op_and_with_constant) ? (i_opd & i_const) :
        (i_op == op_or) ? (i_opd | i_ops) :
        (i_op == op_or_with_constant) ? (i_opd | i_const) :
        (i_op == op_exclusive_or) ? (i_opd ^ i_ops) :
        (i_op == op_clear_bits_by_mask) ? (i_opd & clear_mask) :
        (i_opd & i_opd);

    // Products through one signed 9x9 multiplier.
    wire a_sgn = (i_op == op_signed_product) | (i_op == op_mixed_sign_product)
        | (i_op == op_fractional_signed_product) | (i_op == op_fractional_mixed_product);
    wire b_sgn = (i_op == op_signed_product) | (i_op == op_fractional_signed_product);
    wire frac = (i_op == op_fractional_unsigned_product)
        | (i_op == op_fractional_signed_product) | (i_op == op_fractional_mixed_product);
    wire signed [8:0] a_ext = {a_sgn & i_opd[7], i_opd};
    wire signed [8:0] b_ext = {b_sgn & i_ops[7], i_ops};
    wire signed [17:0] prod_w = a_ext * b_ext;
    wire [15:0] prod = prod_w[15:0];
    wire [15:0] prod_out = frac ? {prod[14:0], 1'b0} : prod;

    // Program counter candidates.
    wire [PC_W-1:0] ofs_ext = {{(PC_W-OFS_W){i_offset[OFS_W-1]}}, i_offset};
    wire [PC_W-1:0] pc_inc1 = i_pc + PC_W'(1);
    wire [PC_W-1:0] pc_inc2 = i_pc + PC_W'(2);
    wire [PC_W-1:0] pc_inc3 = i_pc + PC_W'(3);
    wire [PC_W-1:0] pc_rel = pc_inc1 + ofs_ext;
    wire [23:0] ext_z_full = {i_jump_high_extension, i_zptr};
    wire [PC_W-1:0] ext_z = ext_z_full[PC_W-1:0];

    // Skip and branch conditions.
    wire skip_cond =
        (i_op == op_compare_skip_equal) ? (i_opd == i_ops) :
        (i_op == op_skip_reg_bit_clear) ? ~i_ops[i_bit_sel] :
        (i_op == op_skip_reg_bit_set) ? i_ops[i_bit_sel] :
        (i_op == op_skip_io_bit_clear) ? ~i_io_val[i_bit_sel] :
        i_io_val[i_bit_sel];
    wire n_xor_v = i_status[`CBE_FLAG_N] ^ i_status[`CBE_FLAG_V];
    wire br_cond =
        (i_op == op_branch_flag_set) ? i_status[i_flag_sel] :
        (i_op == op_branch_flag_clear) ? ~i_status[i_flag_sel] :
        (i_op == op_branch_signed_ge) ? ~n_xor_v :
        (i_op == op_branch_signed_lt) ? n_xor_v :
        (i_op == op_branch_unsigned_ge) ? ~i_status[`CBE_FLAG_C] :
        (i_op == op_branch_unsigned_lt) ? i_status[`CBE_FLAG_C] :
        (i_op == op_branch_half_carry_set) ? i_status[`CBE_FLAG_H] :
        ~i_status[`CBE_FLAG_H];

    always_comb begin
        res_nxt = i_opd;
        hi_nxt = `CBE_BYTE_RST;
        st_nxt = i_status;
        wr_dst_nxt = 1'b0;
        wr_pair_nxt = 1'b0;
        wr_prod_nxt = 1'b0;
        st_wr_nxt = 1'b0;
        pc_nxt = pc_inc1;
        push_nxt = 1'b0;
        ret_nxt = pc_inc1;
        cyc_nxt = `CBE_CYC_ONE;
        unique case (i_op)
            op_add, op_add_carry, op_sub, op_subtract_constant, op_sub_carry,
            op_subtract_constant_with_borrow, op_compare, op_compare_with_borrow,
            op_compare_immediate: begin
                res_nxt = sum;
                wr_dst_nxt = ~is_cmp;
                st_wr_nxt = 1'b1;
                st_nxt[`CBE_FLAG_Z] = add_z;
                st_nxt[`CBE_FLAG_C] = add_c;
                st_nxt[`CBE_FLAG_N] = sum[7];
                st_nxt[`CBE_FLAG_V] = add_v;
                st_nxt[`CBE_FLAG_H] = add_h;
            end
            op_word_immediate_add, op_word_immediate_subtract: begin
                res_nxt = w_res[7:0];
                hi_nxt = w_res[15:8];
                wr_pair_nxt = 1'b1;
                st_wr_nxt = 1'b1;
                st_nxt[`CBE_FLAG_Z] = w_res == 16'h0000;
                st_nxt[`CBE_FLAG_C] = w_c;
                st_nxt[`CBE_FLAG_N] = w_res[15];
                st_nxt[`CBE_FLAG_V] = w_v;
                st_nxt[`CBE_FLAG_S] = w_res[15] ^ w_v;
                cyc_nxt = `CBE_CYC_TWO;
            end
            // Logic group; clear mask; test keeps the register.
            op_and, op_and_with_constant, op_or, op_or_with_constant, op_exclusive_or,
            op_clear_bits_by_mask, op_test_zero_or_negative: begin
                res_nxt = log_res;
                wr_dst_nxt = i_op != op_test_zero_or_negative;
                st_wr_nxt = 1'b1;
                st_nxt[`CBE_FLAG_Z] = log_res == `CBE_BYTE_RST;
                st_nxt[`CBE_FLAG_N] = log_res[7];
                st_nxt[`CBE_FLAG_V] = 1'b0;
            end
            op_unsigned_product, op_signed_product, op_mixed_sign_product,
            op_fractional_unsigned_product, op_fractional_signed_product,
            op_fractional_mixed_product: begin
                res_nxt = prod_out[7:0];
                hi_nxt = prod_out[15:8];
                wr_prod_nxt = 1'b1;
                st_wr_nxt = 1'b1;
                st_nxt[`CBE_FLAG_Z] = prod_out == 16'h0000;
                st_nxt[`CBE_FLAG_C] = prod[15];
                cyc_nxt = `CBE_CYC_TWO;
            end
            op_relative_subroutine_call: begin
                pc_nxt = pc_rel;
                push_nxt = 1'b1;
                cyc_nxt = `CBE_CYC_FOUR;
            end
            op_extended_indirect_jump: begin
                pc_nxt = ext_z;
                cyc_nxt = `CBE_CYC_TWO;
            end
            op_extended_indirect_call: begin
                pc_nxt = ext_z;
                push_nxt = 1'b1;
                cyc_nxt = `CBE_CYC_FOUR;
            end
            op_direct_jump: begin
                pc_nxt = i_target;
                cyc_nxt = `CBE_CYC_THREE;
            end
            // Direct call returns past its own two words.
            op_direct_call: begin
                pc_nxt = i_target;
                push_nxt = 1'b1;
                ret_nxt = pc_inc2;
                cyc_nxt = `CBE_CYC_FIVE;
            end
            op_compare_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set,
            op_skip_io_bit_clear, op_skip_io_bit_set: begin
                if (skip_cond) begin
                    pc_nxt = i_next_two_word ? pc_inc3 : pc_inc2;
                    cyc_nxt = i_next_two_word ? `CBE_CYC_THREE : `CBE_CYC_TWO;
                end
            end
            op_branch_flag_set, op_branch_flag_clear, op_branch_signed_ge,
            op_branch_signed_lt, op_branch_unsigned_ge, op_branch_unsigned_lt,
            op_branch_half_carry_set, op_branch_half_carry_clear: begin
                if (br_cond) begin
                    pc_nxt = pc_rel;
                    cyc_nxt = `CBE_CYC_TWO;
                end
            end
            default: begin
                cyc_nxt = `CBE_CYC_ONE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= `CBE_CYC_IDLE;
        end else if (take) begin
            cnt_r <= cyc_nxt;
        end else if (o_busy) begin
            cnt_r <= cnt_r - `CBE_CYC_ONE;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_result_r <= `CBE_BYTE_RST;
            o_result_hi_r <= `CBE_BYTE_RST;
            o_wr_dst_r <= 1'b0;
            o_wr_pair_r <= 1'b0;
            o_wr_product_r <= 1'b0;
            o_status_r <= `CBE_STATUS_RST;
            o_status_wr_r <= 1'b0;
            o_pc_next_r <= '0;
            o_push_r <= 1'b0;
            o_ret_addr_r <= '0;
        end else if (take) begin
            o_result_r <= res_nxt;
            o_result_hi_r <= hi_nxt;
            o_wr_dst_r <= wr_dst_nxt;
            o_wr_pair_r <= wr_pair_nxt;
            o_wr_product_r <= wr_prod_nxt;
            o_status_r <= st_nxt;
            o_status_wr_r <= st_wr_nxt;
            o_pc_next_r <= pc_nxt;
            o_push_r <= push_nxt;
            o_ret_addr_r <= ret_nxt;
        end
    end

    add_sum_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_add |=> o_result_r == 8'($past(i_opd) + $past(i_ops))
            && o_wr_dst_r && o_done)
        else $error("byte add result or timing wrong");
    word_two_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_word_immediate_add |=> o_wr_pair_r && !o_done ##1 o_done)
        else $error("word add not two cycles");
    word_sub_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_word_immediate_subtract
            |=> {o_result_hi_r, o_result_r} == 16'($past(i_pair) - {10'h000, $past(i_const[5:0])}))
        else $error("word subtract result wrong");
    logic_flags_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_or |=> !o_status_r[`CBE_FLAG_V]
            && o_status_r[`CBE_FLAG_C] == $past(i_status[`CBE_FLAG_C]))
        else $error("logic op touched wrong flags");
    clear_mask_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_clear_bits_by_mask
            |=> o_result_r == ($past(i_opd) & ~$past(i_const)))
        else $error("clear mask result wrong");
    test_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_test_zero_or_negative |=> !o_wr_dst_r
            && o_status_r[`CBE_FLAG_N] == o_result_r[7] && o_result_r == $past(i_opd))
        else $error("test changed register or flags wrong");
    product_place_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_unsigned_product
            |=> {o_result_hi_r, o_result_r} == 16'($past(i_opd)) * 16'($past(i_ops)) ##1 o_done)
        else $error("unsigned product wrong");
    rel_call_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_relative_subroutine_call |=> o_push_r && !o_status_wr_r
            && o_ret_addr_r == $past(i_pc) + PC_W'(1) ##0 !o_done [*3] ##1 o_done)
        else $error("relative call wrong");
    ext_jump_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_extended_indirect_jump |=> !o_push_r && !o_done ##1 o_done)
        else $error("extended jump timing wrong");
    direct_call_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_direct_call |=> o_pc_next_r == $past(i_target)
            && o_ret_addr_r == $past(i_pc) + PC_W'(2) ##0 !o_done [*4] ##1 o_done)
        else $error("direct call wrong");
    skip_equal_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_compare_skip_equal && i_opd == i_ops && i_next_two_word
            |=> o_pc_next_r == $past(i_pc) + PC_W'(3) ##0 !o_done [*2] ##1 o_done)
        else $error("skip over two-word instruction wrong");
    compare_keep_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && is_cmp |=> !o_wr_dst_r && o_status_wr_r)
        else $error("compare stored its difference");
    branch_ge_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_branch_signed_ge && !n_xor_v
            |=> o_pc_next_r == $past(pc_rel) && !o_done ##1 o_done)
        else $error("signed ge branch not taken");
    branch_lo_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        take && i_op == op_branch_unsigned_lt && !i_status[`CBE_FLAG_C]
            |=> o_pc_next_r == $past(i_pc) + PC_W'(1) && o_done)
        else $error("unsigned lower branch wrongly taken");
endmodule // cbe_exec_core

// ==== common/cbe_cfg.svh ====
// Constants for the arithmetic and branch execution unit.
`ifndef CBE_CFG_SVH
`define CBE_CFG_SVH

`define CBE_FLAG_C 0
`define CBE_FLAG_Z 1
`define CBE_FLAG_N 2
`define CBE_FLAG_V 3
`define CBE_FLAG_S 4
`define CBE_FLAG_H 5

`define CBE_STATUS_RST 8'h00
`define CBE_BYTE_RST 8'h00
`define CBE_ALL_ONES 8'hff

`define CBE_CYC_IDLE 3'h0
`define CBE_CYC_ONE 3'h1
`define CBE_CYC_TWO 3'h2
`define CBE_CYC_THREE 3'h3
`define CBE_CYC_FOUR 3'h4
`define CBE_CYC_FIVE 3'h5

`endif

// ==== common/cbe_pkg.sv ====
// Operation codes of the arithmetic and branch execution unit.
package cbe_pkg;

    typedef enum logic [5:0] {
        op_add = 6'h00, op_add_carry = 6'h01, op_sub = 6'h02,
        op_subtract_constant = 6'h03, op_sub_carry = 6'h04,
        op_subtract_constant_with_borrow = 6'h05, op_word_immediate_add = 6'h06,
        op_word_immediate_subtract = 6'h07, op_and = 6'h08, op_and_with_constant = 6'h09,
        op_or = 6'h0a, op_or_with_constant = 6'h0b, op_exclusive_or = 6'h0c,
        op_clear_bits_by_mask = 6'h0d, op_test_zero_or_negative = 6'h0e,
        op_compare = 6'h0f, op_compare_with_borrow = 6'h10, op_compare_immediate = 6'h11,
        op_unsigned_product = 6'h12, op_signed_product = 6'h13,
        op_mixed_sign_product = 6'h14, op_fractional_unsigned_product = 6'h15,
        op_fractional_signed_product = 6'h16, op_fractional_mixed_product = 6'h17,
        op_relative_subroutine_call = 6'h18, op_extended_indirect_jump = 6'h19,
        op_extended_indirect_call = 6'h1a, op_direct_jump = 6'h1b,
        op_direct_call = 6'h1c, op_compare_skip_equal = 6'h1d,
        op_skip_reg_bit_clear = 6'h1e, op_skip_reg_bit_set = 6'h1f,
        op_skip_io_bit_clear = 6'h20, op_skip_io_bit_set = 6'h21,
        op_branch_flag_set = 6'h22, op_branch_flag_clear = 6'h23,
        op_branch_signed_ge = 6'h24, op_branch_signed_lt = 6'h25,
        op_branch_unsigned_ge = 6'h26, op_branch_unsigned_lt = 6'h27,
        op_branch_half_carry_set = 6'h28, op_branch_half_carry_clear = 6'h29
    } cbe_op_type;

endpackage

// ==== design/cbe_add8.sv ====
// Eight-bit adder and subtractor with carry, half-carry and overflow.
`timescale 1ns/100ps
module cbe_add8 (
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_cin,
    input wire logic i_sub,
    output logic [7:0] o_sum,
    output logic o_carry,
    output logic o_half,
    output logic o_ovf
);
    wire [8:0] add_w = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
    wire [8:0] sub_w = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
    wire [8:0] res_w = i_sub ? sub_w : add_w;
    wire [7:0] r = res_w[7:0];
    wire h_add = (i_a[3] & i_b[3]) | (i_b[3] & ~r[3]) | (~r[3] & i_a[3]);
    wire h_sub = (~i_a[3] & i_b[3]) | (i_b[3] & r[3]) | (r[3] & ~i_a[3]);
    wire v_add = (i_a[7] & i_b[7] & ~r[7]) | (~i_a[7] & ~i_b[7] & r[7]);
    wire v_sub = (i_a[7] & ~i_b[7] & ~r[7]) | (~i_a[7] & i_b[7] & r[7]);

    // The ninth bit is the carry when adding and the borrow when subtracting.
    assign o_sum = r;
    assign o_carry = res_w[8];
    assign o_half = i_sub ? h_sub : h_add;
    assign o_ovf = i_sub ? v_sub : v_add;
endmodule // cbe_add8

// ==== bench/tb_top.sv ====
// Self-checking testbench for the arithmetic and branch execution unit.
`timescale 1ns/100ps
module tb_top;
    import cbe_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_start = 1'b0;
    cbe_op_type i_op = op_add;
    logic [7:0] i_opd = 8'h00, i_ops = 8'h00, i_const = 8'h00, i_status = 8'h00;
    logic [7:0] i_io_val = 8'h00, i_jump_high_extension = 8'h01;
    logic [15:0] i_pair = 16'h0000, i_zptr = 16'h2345;
    logic [21:0] i_pc = 22'h000064, i_target = 22'h3abcde;
    logic [11:0] i_offset = 12'h000;
    logic [2:0] i_bit_sel = 3'h3, i_flag_sel = 3'h0;
    logic i_next_two_word = 1'b0;
    logic o_busy, o_done, o_wr_dst_r, o_wr_pair_r, o_wr_product_r, o_status_wr_r, o_push_r;
    logic [7:0] o_result_r, o_result_hi_r, o_status_r;
    logic [21:0] o_pc_next_r, o_ret_addr_r;
    int miscompares = 0;
    int samples_checked = 0;
    cbe_exec_core #(.PC_W(22), .OFS_W(12)) dut (.i_ref_clk, .i_rst, .i_start, .i_op, .i_opd,
        .i_ops, .i_const, .i_pair, .i_status, .i_pc, .i_offset, .i_target, .i_zptr,
        .i_jump_high_extension, .i_bit_sel, .i_flag_sel, .i_io_val, .i_next_two_word,
        .o_busy, .o_done, .o_result_r, .o_result_hi_r, .o_wr_dst_r, .o_wr_pair_r,
        .o_wr_product_r, .o_status_r, .o_status_wr_r, .o_pc_next_r, .o_push_r, .o_ret_addr_r);
    initial forever #2.5 i_ref_clk = ~i_ref_clk;
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Issues one operation and counts the cycles up to the done pulse.
    task automatic run(input cbe_op_type op, input int cyc);
        int n;
        n = 1;
        @(negedge i_ref_clk);
        i_op = op;
        i_start = 1'b1;
        @(negedge i_ref_clk);
        i_start = 1'b0;
        while (o_done !== 1'b1 && n < 8) begin
            @(negedge i_ref_clk);
            n++;
        end
        if (o_done !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end else begin
            chk("cycles", cyc, n);
        end
    endtask
    task automatic bop(input cbe_op_type op, input logic [7:0] d, s, k, st, r, f, input logic w);
        i_opd = d;
        i_ops = s;
        i_const = k;
        i_status = st;
        run(op, 1);
        if (w) chk("result", r, o_result_r);
        chk("status", {1'b1, f}, {o_status_wr_r, o_status_r});
        chk("write", w, o_wr_dst_r);
    endtask
    task automatic byte_ops();
        bop(op_add, 8'h0f, 8'h01, 8'h00, 8'h00, 8'h10, 8'h20, 1'b1);
        bop(op_add_carry, 8'hff, 8'h00, 8'h00, 8'h01, 8'h00, 8'h23, 1'b1);
        bop(op_subtract_constant, 8'h10, 8'h00, 8'h01, 8'h00, 8'h0f, 8'h20, 1'b1);
        bop(op_subtract_constant_with_borrow, 8'h10, 8'h00, 8'h0f, 8'h01, 8'h00, 8'h20, 1'b1);
        bop(op_compare_with_borrow, 8'h10, 8'h10, 8'h00, 8'h03, 8'h00, 8'h25, 1'b0);
        bop(op_compare_immediate, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h28, 1'b0);
        bop(op_and, 8'hf0, 8'h8f, 8'h00, 8'h3f, 8'h80, 8'h35, 1'b1);
        bop(op_or_with_constant, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h02, 1'b1);
        bop(op_exclusive_or, 8'ha5, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h02, 1'b1);
        bop(op_clear_bits_by_mask, 8'hff, 8'h00, 8'h0f, 8'h00, 8'hf0, 8'h04, 1'b1);
        bop(op_test_zero_or_negative, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 1'b0);
        bop(op_or, 8'h81, 8'h02, 8'h00, 8'h09, 8'h83, 8'h05, 1'b1);
        bop(op_and_with_constant, 8'h3c, 8'h00, 8'h0f, 8'h00, 8'h0c, 8'h00, 1'b1);
        bop(op_sub, 8'h05, 8'h03, 8'h00, 8'h00, 8'h02, 8'h00, 1'b1);
        bop(op_sub_carry, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h02, 1'b1);
        bop(op_compare, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h25, 1'b0);
    endtask
    task automatic wop(input cbe_op_type op, input int c, input logic [7:0] d, s, f,
        input logic [15:0] r);
        i_opd = d;
        i_ops = s;
        i_status = 8'h00;
        run(op, c);
        chk("wide result", {r, f}, {o_result_hi_r, o_result_r, o_status_r});
        chk("wide write", {c == 2, 1'b1}, {o_wr_pair_r | o_wr_product_r, o_status_wr_r});
    endtask
    task automatic wide_ops();
        i_pair = 16'h00ff;
        i_const = 8'hc1;
        wop(op_word_immediate_add, 2, 8'h00, 8'h00, 8'h00, 16'h0100);
        i_pair = 16'h0000;
        wop(op_word_immediate_subtract, 2, 8'h00, 8'h00, 8'h15, 16'hffff);
        wop(op_unsigned_product, 2, 8'hff, 8'hff, 8'h01, 16'hfe01);
        wop(op_signed_product, 2, 8'hff, 8'hff, 8'h00, 16'h0001);
        wop(op_mixed_sign_product, 2, 8'hff, 8'h02, 8'h01, 16'hfffe);
        wop(op_fractional_unsigned_product, 2, 8'hff, 8'hff, 8'h01, 16'hfc02);
        wop(op_fractional_signed_product, 2, 8'h80, 8'h80, 8'h00, 16'h8000);
        wop(op_fractional_mixed_product, 2, 8'hff, 8'h02, 8'h01, 16'hfffc);
    endtask
    task automatic fop(input cbe_op_type op, input int c, input logic [21:0] pcn, ret,
        input logic p);
        run(op, c);
        chk("next pc", pcn, o_pc_next_r);
        chk("push", {p, p ? ret : 22'h0}, {o_push_r, p ? o_ret_addr_r : 22'h0});
        chk("flags kept", {1'b0, i_status}, {o_status_wr_r, o_status_r});
    endtask
    task automatic flow_ops();
        i_offset = 12'hffe;
        i_status = 8'h2b;
        fop(op_relative_subroutine_call, 4, 22'h000063, 22'h000065, 1'b1);
        fop(op_extended_indirect_jump, 2, 22'h012345, 22'h0, 1'b0);
        fop(op_extended_indirect_call, 4, 22'h012345, 22'h000065, 1'b1);
        fop(op_direct_call, 5, 22'h3abcde, 22'h000066, 1'b1);
        fop(op_direct_jump, 3, 22'h3abcde, 22'h0, 1'b0);
        i_opd = 8'h5a;
        i_ops = 8'h5a;
        i_io_val = 8'h08;
        i_next_two_word = 1'b1;
        fop(op_compare_skip_equal, 3, 22'h000067, 22'h0, 1'b0);
        fop(op_skip_io_bit_clear, 1, 22'h000065, 22'h0, 1'b0);
        i_next_two_word = 1'b0;
        fop(op_skip_io_bit_set, 2, 22'h000066, 22'h0, 1'b0);
        fop(op_skip_reg_bit_set, 2, 22'h000066, 22'h0, 1'b0);
        i_ops = 8'hf7;
        fop(op_skip_reg_bit_set, 1, 22'h000065, 22'h0, 1'b0);
        fop(op_compare_skip_equal, 1, 22'h000065, 22'h0, 1'b0);
        fop(op_skip_reg_bit_clear, 2, 22'h000066, 22'h0, 1'b0);
    endtask
    // A start while busy is refused; one in the done cycle is taken at once.
    task automatic overlap_ops();
        @(negedge i_ref_clk);
        i_op = op_extended_indirect_jump;
        i_start = 1'b1;
        @(negedge i_ref_clk);
        i_op = op_add;
        chk("busy", 1'b1, o_busy);
        @(negedge i_ref_clk);
        chk("refused start", {1'b1, 22'h012345}, {o_done, o_pc_next_r});
        @(negedge i_ref_clk);
        i_start = 1'b0;
        chk("back to back", {1'b1, 22'h000065}, {o_done, o_pc_next_r});
    endtask
    task automatic bra(input cbe_op_type op, input logic [7:0] st, input logic t);
        i_status = st;
        i_offset = 12'h010;
        i_flag_sel = 3'h1;
        fop(op, t ? 2 : 1, t ? 22'h000075 : 22'h000065, 22'h0, 1'b0);
    endtask
    task automatic branch_ops();
        bra(op_branch_flag_set, 8'h02, 1'b1);
        bra(op_branch_flag_clear, 8'h02, 1'b0);
        bra(op_branch_signed_ge, 8'h0c, 1'b1);
        bra(op_branch_signed_lt, 8'h0c, 1'b0);
        bra(op_branch_signed_lt, 8'h04, 1'b1);
        bra(op_branch_unsigned_ge, 8'h01, 1'b0);
        bra(op_branch_unsigned_lt, 8'h01, 1'b1);
        bra(op_branch_unsigned_lt, 8'h00, 1'b0);
        bra(op_branch_half_carry_set, 8'h20, 1'b1);
        bra(op_branch_half_carry_clear, 8'h20, 1'b0);
    endtask
    initial begin
        repeat (20) @(negedge i_ref_clk);
        chk("reset state", 32'h0, {o_busy, o_done, o_push_r, o_pc_next_r});
        i_rst = 1'b0;
        byte_ops();
        wide_ops();
        flow_ops();
        overlap_ops();
        branch_ops();
        report_and_stop();
    end
endmodule // tb_top
